/* File: core/accel_sample_readout_regs.sv */
// Sample output registers of a three-axis accelerometer, reached over Wishbone.
// Assumes samples arrive as one-cycle strobes in the sys_clk domain.
//
// How it works
// - Mode zero: address 0 gives sample flags
// - Mode nonzero: address 0 gives FIFO status
// - Fast-read skips low bytes in auto-increment
// - Otherwise bytes run X,Y,Z high then low
// - Samples are 12-bit two's complement values
// - Status byte: overwrite flags high, ready low
// - Combined overwrite set on loss, cleared by highs
// - Axis overwrite set on loss, cleared by high
// - Combined ready set on sample, cleared by highs
// - Axis ready set on sample, cleared by high
// - Output bytes sit at addresses 1 to 6
// - Low byte valid only right after high
// - High read latches matching low byte
// - FIFO on: address 1 gives FIFO word
// - FIFO on: addresses 2 to 6 read zero
// - Mode field resets to zero, disabled
`timescale 1ns/1ns
module accel_sample_readout_regs #(
  parameter int sample_width = 12 // Bits per axis sample
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sample source
  input wire logic [2:0] sample_valid,
  input wire logic [sample_width-1:0] x_sample,
  input wire logic [sample_width-1:0] y_sample,
  input wire logic [sample_width-1:0] z_sample,
  // FIFO side
  input wire logic [7:0] fifo_status_byte,
  input wire logic [7:0] fifo_read_byte,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0][sample_width-1:0] sample; // Live samples, X at index 0
    logic [2:0] ready; // Per-axis ready flags
    logic [2:0] overwrite; // Per-axis overwrite flags
    logic any_ready; // Combined ready flag
    logic any_overwrite; // Combined overwrite flag
    logic [3:0] held_low; // Low nibble caught at a high read
    logic [7:0] last_read; // Index of the previous byte read
    logic [7:0] port_addr; // Auto-increment pointer
    logic [7:0] fifo_setup; // Mode and watermark
    logic [7:0] control_one; // Fast-read and others
    logic [1:0] irq_status; // Sticky events
    logic [1:0] irq_mask; // Event enables
    logic [31:0] dat; // Read data
    logic ack; // Bus answer
    logic irq; // Interrupt level
  } state_s;

  state_s st;
  state_s next_st;

  // Request decode
  logic req;
  logic [7:0] idx;
  logic fifo_on;
  logic fast_read;
  logic [2:0] high_read;
  logic [7:0] rd_byte;
  logic rd_valid;
  logic [7:0] rd_idx;
  logic [7:0] status_byte;

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign idx = wb_adr_i[9:2];
  assign fifo_on = st.fifo_setup[accel_readout_pkg::fifo_mode_lsb +: 2] != accel_readout_pkg::fifo_mode_off;
  assign fast_read = st.control_one[accel_readout_pkg::fast_read_bit];
  assign status_byte = {st.any_overwrite, st.overwrite[2], st.overwrite[1], st.overwrite[0],
                        st.any_ready, st.ready[2], st.ready[1], st.ready[0]};

  // ------------------------------------------------------------
  // Output byte mux, shared by direct reads and the data port
  // ------------------------------------------------------------
  always_comb begin
    rd_valid = req && !wb_we_i &&
               ((idx <= accel_readout_pkg::idx_z_sample_low) || (idx == accel_readout_pkg::idx_data_port));
    // Data port reads use the pointer as address
    rd_idx = (idx == accel_readout_pkg::idx_data_port) ? st.port_addr : idx;
    rd_byte = accel_readout_pkg::reset_byte;
    high_read = 3'b000;
    if (rd_idx == accel_readout_pkg::idx_sample_status) begin
      // Status view follows the FIFO mode
      rd_byte = fifo_on ? fifo_status_byte : status_byte;
    end else if (fifo_on) begin
      // Only address 1 carries data while the FIFO runs
      rd_byte = (rd_idx == accel_readout_pkg::idx_x_sample_high) ? fifo_read_byte : 8'h00;
    end else if (rd_idx <= accel_readout_pkg::idx_z_sample_low) begin
      if (rd_idx[0]) begin
        // Odd index: high byte, bits 11:4
        rd_byte = st.sample[rd_idx[2:1]][sample_width-1 -: 8];
        high_read[rd_idx[2:1]] = rd_valid;
      end else if (st.last_read == rd_idx - 8'h01) begin
        // Low byte only right after its own high byte
        rd_byte = {st.held_low, 4'h0};
      end
    end
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.dat = 32'h0000_0000;
    if (rd_valid) begin
      next_st.last_read = rd_idx;
      if (high_read != 3'b000) begin
        next_st.held_low = st.sample[rd_idx[2:1]][3:0];
      end
      if (idx == accel_readout_pkg::idx_data_port) begin
        // Pointer walk: fast mode jumps high to next high
        if (rd_idx == accel_readout_pkg::idx_z_sample_low ||
            (fast_read && rd_idx == accel_readout_pkg::idx_z_sample_low - 8'h01)) begin
          next_st.port_addr = accel_readout_pkg::idx_sample_status;
        end else if (fast_read && rd_idx != accel_readout_pkg::idx_sample_status) begin
          next_st.port_addr = st.port_addr + 8'h02;
        end else begin
          next_st.port_addr = st.port_addr + 8'h01;
        end
      end
    end else if (req && !wb_we_i) begin
      next_st.last_read = 8'hff;
    end
    // Register reads
    if (req && !wb_we_i) begin
      case (idx)
        accel_readout_pkg::idx_fifo_setup: next_st.dat = {24'h0, st.fifo_setup};
        accel_readout_pkg::idx_control_one: next_st.dat = {24'h0, st.control_one};
        accel_readout_pkg::idx_irq_status: next_st.dat = {30'h0, st.irq_status};
        accel_readout_pkg::idx_irq_mask: next_st.dat = {30'h0, st.irq_mask};
        accel_readout_pkg::idx_port_addr: next_st.dat = {24'h0, st.port_addr};
        accel_readout_pkg::idx_fifo_word: next_st.dat = {24'h0, fifo_read_byte};
        default: next_st.dat = rd_valid ? {24'h0, rd_byte} : 32'h0000_0000;
      endcase
    end
    // Register writes, low byte lane only
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (idx)
        accel_readout_pkg::idx_fifo_setup: next_st.fifo_setup = wb_dat_i[7:0];
        accel_readout_pkg::idx_control_one: next_st.control_one = wb_dat_i[7:0];
        accel_readout_pkg::idx_irq_status: next_st.irq_status = st.irq_status & ~wb_dat_i[1:0];
        accel_readout_pkg::idx_irq_mask: next_st.irq_mask = wb_dat_i[1:0];
        accel_readout_pkg::idx_port_addr: next_st.port_addr = wb_dat_i[7:0];
        default: next_st.fifo_setup = st.fifo_setup;
      endcase
    end
    // Flag clears by high-byte reads
    next_st.ready = st.ready & ~high_read;
    next_st.overwrite = st.overwrite & ~high_read;
    if (high_read != 3'b000) begin
      next_st.any_ready = 1'b0;
      next_st.any_overwrite = 1'b0;
    end
    // New samples: set wins over clear
    for (int a = 0; a < 3; a++) begin
      if (sample_valid[a]) begin
        next_st.ready[a] = 1'b1;
        if (st.ready[a] && !high_read[a]) begin
          next_st.overwrite[a] = 1'b1;
          next_st.any_overwrite = 1'b1;
        end
      end
    end
    next_st.sample[0] = sample_valid[0] ? x_sample : st.sample[0];
    next_st.sample[1] = sample_valid[1] ? y_sample : st.sample[1];
    next_st.sample[2] = sample_valid[2] ? z_sample : st.sample[2];
    if (sample_valid != 3'b000) begin
      next_st.any_ready = 1'b1;
      next_st.irq_status[accel_readout_pkg::irq_ready_bit] = 1'b1;
    end
    if (next_st.any_overwrite && !st.any_overwrite) begin
      next_st.irq_status[accel_readout_pkg::irq_overwrite_bit] = 1'b1;
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.last_read <= 8'hff;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign irq = st.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
  a_ready_sets: assert property (@(posedge sys_clk) disable iff (reset)
    sample_valid[0] |=> st.ready[0] && st.any_ready) else $error("ready not set");
  a_ready_clears: assert property (@(posedge sys_clk) disable iff (reset)
    (high_read[1] && !sample_valid[1]) |=> !st.ready[1]) else $error("ready not cleared");
  a_overwrite_sets: assert property (@(posedge sys_clk) disable iff (reset)
    (sample_valid[2] && st.ready[2] && !high_read[2]) |=> st.overwrite[2] && st.any_overwrite)
    else $error("overwrite not set");
  a_fifo_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (fifo_on && rd_valid && rd_idx > 8'h01) |=> wb_dat_o == 32'h0) else $error("fifo zero bytes");
  a_status_view: assert property (@(posedge sys_clk) disable iff (reset)
    (!fifo_on && rd_valid && rd_idx == 8'h00 && sample_valid == 3'b000) |=> wb_dat_o[7:0] == status_byte)
    else $error("status view");
  a_high_byte: assert property (@(posedge sys_clk) disable iff (reset)
    (!fifo_on && rd_valid && rd_idx == 8'h03) |=> wb_dat_o[7:0] == $past(st.sample[1][11:4]))
    else $error("high byte");
  a_fast_skip: assert property (@(posedge sys_clk) disable iff (reset)
    (fast_read && rd_valid && idx == 8'h40 && st.port_addr == 8'h01) |=> st.port_addr == 8'h03)
    else $error("fast skip");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    irq == |(st.irq_status & st.irq_mask)) else $error("irq level");

  // ------------------------------------------------------------
  // Multi-step checks on the X high and low pair
  // ------------------------------------------------------------
  // X high byte taken while the live view is on
  sequence s_x_high_read;
    !fifo_on && rd_valid && rd_idx == 8'h01;
  endsequence

  // X low byte read straight after its high byte
  sequence s_x_low_follow;
    !fifo_on && rd_valid && rd_idx == 8'h02 && st.last_read == 8'h01;
  endsequence

  // X low byte read with no high byte before it
  sequence s_x_low_alone;
    !fifo_on && rd_valid && rd_idx == 8'h02 && st.last_read != 8'h01;
  endsequence

  // The high read must freeze the matching nibble
  a_low_coherent: assert property (@(posedge sys_clk) disable iff (reset)
    s_x_high_read |=> st.held_low == $past(st.sample[0][3:0]))
    else $error("low nibble not held");

  // The paired low read returns the frozen nibble
  a_low_after_high: assert property (@(posedge sys_clk) disable iff (reset)
    s_x_low_follow |=> wb_dat_o[7:0] == {$past(st.held_low), 4'h0})
    else $error("paired low byte");

  // A lone low read yields no sample data
  a_low_isolated: assert property (@(posedge sys_clk) disable iff (reset)
    s_x_low_alone |=> wb_dat_o == 32'h0000_0000)
    else $error("lone low byte");

  // Any read outside the output range breaks a pair
  a_last_read_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (req && !wb_we_i && !rd_valid) |=> st.last_read == 8'hff)
    else $error("pair not broken");

  // ------------------------------------------------------------
  // FIFO view
  // ------------------------------------------------------------
  // Address 1 shows the byte at the FIFO read pointer
  a_fifo_word: assert property (@(posedge sys_clk) disable iff (reset)
    (fifo_on && rd_valid && rd_idx == 8'h01) |=> wb_dat_o[7:0] == $past(fifo_read_byte))
    else $error("fifo word");

  // Address 0 shows FIFO status while the mode is nonzero
  a_fifo_status: assert property (@(posedge sys_clk) disable iff (reset)
    (fifo_on && rd_valid && rd_idx == 8'h00) |=> wb_dat_o[7:0] == $past(fifo_status_byte))
    else $error("fifo status");

  // ------------------------------------------------------------
  // Pointer walk
  // ------------------------------------------------------------
  // Full mode steps one byte at a time
  a_full_step: assert property (@(posedge sys_clk) disable iff (reset)
    (!fast_read && rd_valid && idx == 8'h40 && st.port_addr < 8'h06) |=> st.port_addr == $past(st.port_addr) + 8'h01)
    else $error("full step");

  // The last low byte wraps back to status
  a_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    (rd_valid && idx == 8'h40 && st.port_addr == 8'h06) |=> st.port_addr == 8'h00)
    else $error("pointer wrap");

  // Fast mode wraps after the Z high byte
  a_fast_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    (fast_read && rd_valid && idx == 8'h40 && st.port_addr == 8'h05) |=> st.port_addr == 8'h00)
    else $error("fast wrap");

  // Software can place the pointer
  a_port_write: assert property (@(posedge sys_clk) disable iff (reset)
    (req && wb_we_i && wb_sel_i[0] && idx == 8'h43) |=> st.port_addr == $past(wb_dat_i[7:0]))
    else $error("pointer write");

  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------
  // Ack is a single-cycle pulse
  a_ack_drops: assert property (@(posedge sys_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  // No request, no answer
  a_no_ack_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("stray ack");

  // Data lines stay quiet outside an answer
  a_dat_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("data not quiet");

  // Unmapped indices read zero
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (req && !wb_we_i && idx == 8'h7f) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read");

  // ------------------------------------------------------------
  // Flags and samples
  // ------------------------------------------------------------
  // X high read clears the X overwrite flag
  a_ow_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (high_read[0] && !sample_valid[0]) |=> !st.overwrite[0])
    else $error("overwrite not cleared");

  // Any high read clears combined ready
  a_any_ready_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (high_read != 3'b000 && sample_valid == 3'b000) |=> !st.any_ready)
    else $error("combined ready stuck");

  // Any high read clears combined overwrite
  a_any_ow_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (high_read != 3'b000 && sample_valid == 3'b000) |=> !st.any_overwrite)
    else $error("combined overwrite stuck");

  // A sample in the clearing cycle keeps ready set
  a_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
    (sample_valid[1] && high_read[1]) |=> st.ready[1])
    else $error("set lost to clear");

  // Any new sample raises combined ready
  a_any_ready_set: assert property (@(posedge sys_clk) disable iff (reset)
    (sample_valid != 3'b000) |=> st.any_ready)
    else $error("combined ready not set");

  // A Z strobe captures the Z sample word
  a_sample_take: assert property (@(posedge sys_clk) disable iff (reset)
    sample_valid[2] |=> st.sample[2] == $past(z_sample))
    else $error("sample not taken");

  // Z high byte carries the top eight bits
  a_high_z: assert property (@(posedge sys_clk) disable iff (reset)
    (!fifo_on && rd_valid && rd_idx == 8'h05) |=> wb_dat_o[7:0] == $past(st.sample[2][11:4]))
    else $error("z high byte");

  // ------------------------------------------------------------
  // Interrupt registers
  // ------------------------------------------------------------
  // Unmasked new-sample event raises the line
  a_irq_set: assert property (@(posedge sys_clk) disable iff (reset)
    (sample_valid != 3'b000 && st.irq_mask[0] && !(req && wb_we_i)) |=> irq)
    else $error("irq not raised");

  // Writing one clears the sticky event
  a_w1c: assert property (@(posedge sys_clk) disable iff (reset)
    (req && wb_we_i && wb_sel_i[0] && idx == 8'h41 && wb_dat_i[0] && sample_valid == 3'b000)
    |=> !st.irq_status[0])
    else $error("event not cleared");

  // Mask takes the written bits
  a_mask_write: assert property (@(posedge sys_clk) disable iff (reset)
    (req && wb_we_i && wb_sel_i[0] && idx == 8'h42) |=> st.irq_mask == $past(wb_dat_i[1:0]))
    else $error("mask write");

endmodule

/* File: core/accel_readout_pkg.sv */
// Constants shared by the sample readout register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package accel_readout_pkg;

  // ------------------------------------------------------------
  // Register map: byte addresses are four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] idx_sample_status = 8'h00; // Status or FIFO status
  localparam logic [7:0] idx_x_sample_high = 8'h01; // First output byte
  localparam logic [7:0] idx_z_sample_low = 8'h06; // Last output byte
  localparam logic [7:0] idx_fifo_setup = 8'h09; // Mode field bits 7:6
  localparam logic [7:0] idx_control_one = 8'h2a; // Fast-read bit 1
  localparam logic [7:0] idx_data_port = 8'h40; // Byte read with auto-increment
  localparam logic [7:0] idx_irq_status = 8'h41; // Sticky events, write one to clear
  localparam logic [7:0] idx_irq_mask = 8'h42; // Interrupt enables
  localparam logic [7:0] idx_port_addr = 8'h43; // Auto-increment pointer
  localparam logic [7:0] idx_fifo_word = 8'h44; // Word at the FIFO read pointer

  // ------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------
  localparam int fast_read_bit = 1;
  localparam int fifo_mode_lsb = 6;
  localparam logic [1:0] fifo_mode_off = 2'h0; // Reset value, FIFO disabled
  localparam logic [7:0] reset_byte = 8'h00;
  localparam int irq_ready_bit = 0; // Event: new sample set
  localparam int irq_overwrite_bit = 1; // Event: sample overwritten
  localparam int irq_width = 2;

endpackage

/* File: verif/wb_host_model.sv */
// Host side of the register bus: a classic Wishbone single-cycle master.
// Assumes callers enter xfer just after a rising edge of sys_clk.
`timescale 1ns/1ns
module wb_host_model (
  // Clock
  input wire logic sys_clk,
  // Request towards the slave (cyc and stb share req)
  output logic req,
  output logic we,
  output logic [9:0] adr,
  output logic [31:0] wdat,
  // Answer from the slave
  input wire logic [31:0] rdat,
  input wire logic ack
);
  // Idle bus from time zero
  initial begin
    req = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    wdat = 32'h00000000;
  end

  // One transfer, held until ack is sampled high; the bench timeout guards a dead slave
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    req <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, wd};
    @(posedge sys_clk);
    while (ack !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = rdat[7:0];
    req <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the sample readout block with a behavioural flag model.
// Assumes the host model owns the bus; the bench drives samples and FIFO levels.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic sys_clk, reset, req, we, ack, irq;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [2:0] sample_valid;
  logic [11:0] smp[3], val[3], held[3];
  logic [7:0] fstat, fbyte, got, prev, e;
  logic [7:0] fseq[5] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h00}; // Fast-read pointer walk
  bit rdy[3], ow[3], anyr, anyo; // Model flags
  int n_errors, total_checks, cycles, seed;

  wb_host_model host (.sys_clk(sys_clk), .req(req), .we(we), .adr(adr), .wdat(wdat), .rdat(rdat), .ack(ack));
  accel_sample_readout_regs uut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_valid(sample_valid),
    .x_sample(smp[0]), .y_sample(smp[1]), .z_sample(smp[2]), .fifo_status_byte(fstat), .fifo_read_byte(fbyte), .irq(irq));

  // Clock and hang guard
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      test_done();
    end
  end

  // New samples on the axes in m; overwrite when ready still set
  task automatic push(input logic [2:0] m);
    logic [11:0] v;
    for (int a = 0; a < 3; a++) begin
      v = 12'($random(seed));
      if (m[a]) begin
        smp[a] <= v;
        val[a] = v;
        if (rdy[a]) begin ow[a] = 1; anyo = 1; end
        rdy[a] = 1;
        anyr = 1;
      end
    end
    sample_valid <= m;
    @(posedge sys_clk);
    sample_valid <= 3'h0;
    @(posedge sys_clk);
  endtask

  // Read through idx, model index mi; high read latches low and clears flags
  task automatic rdm(input logic [7:0] idx, input logic [7:0] mi);
    int a;
    a = (mi - 1) / 2;
    if (mi == 0) e = {anyo, ow[2], ow[1], ow[0], anyr, rdy[2], rdy[1], rdy[0]};
    else if (mi[0]) begin e = val[a][11:4]; held[a] = val[a]; rdy[a] = 0; ow[a] = 0; anyr = 0; anyo = 0; end
    else e = (prev == mi - 1) ? {held[a][3:0], 4'h0} : 8'h00;
    host.xfer(1'b0, idx, 8'h00, got);
    prev = mi;
    `CHK(got, e)
  endtask
  task automatic rdx(input logic [7:0] idx, input logic [7:0] ex);
    host.xfer(1'b0, idx, 8'h00, got);
    prev = idx;
    `CHK(got, ex)
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, d, got);
  endtask
  task automatic test_done;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 25;
    sys_clk = 0;
    reset = 1;
    sample_valid = 0;
    fstat = 0;
    fbyte = 0;
    prev = 8'hff;
    for (int a = 0; a < 3; a++) begin smp[a] = 0; val[a] = 0; held[a] = 0; end
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    rdx(8'h00, 8'h00);
    rdx(8'h09, 8'h00);
    rdx(8'h7f, 8'h00);
    $display("Test reset values done");
    push(3'h7);
    wr(8'h43, 8'h00);
    for (int i = 0; i < 8; i++) rdm(8'h40, 8'(i % 7));
    $display("Test full burst done");
    push(3'h5);
    push(3'h7);
    rdm(8'h00, 8'h00);
    rdm(8'h05, 8'h05);
    rdm(8'h00, 8'h00);
    rdm(8'h03, 8'h03);
    push(3'h2);
    rdm(8'h04, 8'h04);
    rdm(8'h06, 8'h06);
    rdm(8'h00, 8'h00);
    $display("Test flags and coherence done");
    wr(8'h2a, 8'h02);
    wr(8'h43, 8'h00);
    push(3'h7);
    for (int i = 0; i < 5; i++) rdm(8'h40, fseq[i]);
    wr(8'h2a, 8'h00);
    $display("Test fast read done");
    for (int m = 1; m < 4; m++) begin
      fstat <= 8'($random(seed));
      fbyte <= 8'($random(seed));
      wr(8'h09, 8'(m << 6));
      rdx(8'h00, fstat);
      rdx(8'h01, fbyte);
      for (int k = 2; k < 7; k++) rdx(8'(k), 8'h00);
    end
    wr(8'h09, 8'h00);
    rdm(8'h00, 8'h00);
    $display("Test FIFO redirect done");
    wr(8'h41, 8'h03);
    wr(8'h42, 8'h01);
    push(3'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rdx(8'h41, 8'h01);
    wr(8'h42, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wr(8'h42, 8'h01);
    wr(8'h41, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    $display("Test interrupt done");
    test_done();
  end
endmodule
